// [verilog/slsoc_pkg.sv]
// Package: constants and types for the serial low-side output controller
package slsoc_pkg;
  localparam int          SLSOC_WORD_BITS     = 8;              // Bits in one serial frame
  localparam logic [7:0]  SLSOC_CTRL_RESET    = 8'h00;          // All outputs off at reset
  localparam logic [31:0] SLSOC_ADDR_CTRL     = 32'h0000_0000;  // Control register (RW)
  localparam logic [31:0] SLSOC_ADDR_STATUS   = 32'h0000_0004;  // Status register (RO)
  localparam logic [31:0] SLSOC_ADDR_DRIVE    = 32'h0000_0008;  // Driver state (RO)
  localparam int          SLSOC_ST_FORCE_BIT  = 0;              // Status: force input level
  localparam int          SLSOC_ST_FRAME_BIT  = 1;              // Status: frame in progress
  localparam int          SLSOC_ST_COUNT_LSB  = 8;              // Status: frame count low bit
  localparam int          SLSOC_ST_COUNT_MSB  = 15;             // Status: frame count high bit
  localparam int          SLSOC_SELECT_TO_CLOCK_DELAY_NS = 10;  // Least select-to-clock time
  localparam int          SLSOC_MCLK_PERIOD_NS = 50;            // System clock period
  localparam int          SLSOC_SELECT_TO_CLOCK_DELAY_CYC =
    (SLSOC_SELECT_TO_CLOCK_DELAY_NS + SLSOC_MCLK_PERIOD_NS - 1) / SLSOC_MCLK_PERIOD_NS; // Rounded up

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } slsoc_apb_req_type;
endpackage

// [verilog/slsoc_top.sv]
// Serial low-side output controller: serial slave, control register, drivers, APB view
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - One 8-bit word per frame, external clock
// R2 - Single register holds all output states
// R3 - Serial input ignored while select high
// R4 - Master waits after select before clocking
// R5 - Select rising edge commits word to register
// R6 - Serial clock stays low while deselected
// R7 - Bit one turns output on, default off
// R8 - Force low: output one follows bit
// R9 - Force high: output one always on
// R10 - Reset clears register, all outputs off
// R11 - Rising edge sampling, MSB first, last eight
module slsoc_top (
  input  wire logic                        mclk,                  // System clock, 20 MHz
  input  wire logic                        sys_rst,               // Async reset, active high
  input  wire logic                        serialClock,           // Link clock from controller
  input  wire logic                        select_n,              // Frame select, active low
  input  wire logic                        serialData,            // Serial data in
  input  wire logic                        out_one_force_on,      // Force output one on
  input  wire slsoc_pkg::slsoc_apb_req_type apbReq,               // APB request
  output logic                             pready,                // APB ready
  output logic                             pslverr,               // APB error
  output logic [31:0]                      prdata,                // APB read data
  output logic [7:0]                       driver_on_bits,        // Low-side driver states
  output logic                             low_side_driver_one    // Driver one, mirror of bit 0
);

  // Link domain: shift register, only live while select is low
  logic [7:0] shiftReg;       // Bits gathered in the current frame
  logic [7:0] capturedWord;   // Word held at select rise
  logic       commitToggle;   // Flips once per committed frame

  // Shift on rising serial clock while selected; only sys_rst clears it, so
  // a frame keeps the last eight bits shifted in, with no clock edge needed after the frame
  always_ff @(posedge serialClock or posedge sys_rst) begin
    if (sys_rst) begin
      shiftReg <= 8'h00;                                        // [R10]
    end else if (!select_n) begin                               // [R3]
      shiftReg <= {shiftReg[6:0], serialData};                  // [R11] [R1]
    end
  end

  // Capture at select rise; serial clock is low there so shiftReg is stable
  always_ff @(posedge select_n or posedge sys_rst) begin
    if (sys_rst) begin
      capturedWord <= 8'h00;                                    // [R10]
      commitToggle <= 1'b0;
    end else begin
      capturedWord <= shiftReg;                                 // [R5] [R6]
      commitToggle <= ~commitToggle;                            // [R5]
    end
  end

  // System domain: synchronisers for toggle, select and force input
  logic [2:0] toggleSync;     // Toggle sync, bit 2 is edge history
  logic [1:0] selectSync;     // Select level sync
  logic [1:0] forceSync;      // Force input sync
  logic [7:0] ctrlReg;        // Output control register
  logic [7:0] frameCount;     // Committed frame counter

  // Two-stage crossing; only stage 1 onward is read by logic
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      toggleSync <= 3'h0;
      selectSync <= 2'h3;
      forceSync  <= 2'h0;
    end else begin
      toggleSync <= {toggleSync[1:0], commitToggle};
      selectSync <= {selectSync[0], select_n};
      forceSync  <= {forceSync[0], out_one_force_on};
    end
  end

  wire commitPulse = toggleSync[2] ^ toggleSync[1];   // One cycle per frame
  wire forceLevel  = forceSync[1];                    // Clean force level
  wire frameActive = ~selectSync[1];                  // Frame in progress

  // APB decode
  wire apbAccess = apbReq.psel & apbReq.penable;
  wire hitCtrl   = (apbReq.paddr == slsoc_pkg::SLSOC_ADDR_CTRL);
  wire hitStatus = (apbReq.paddr == slsoc_pkg::SLSOC_ADDR_STATUS);
  wire hitDrive  = (apbReq.paddr == slsoc_pkg::SLSOC_ADDR_DRIVE);
  wire hitAny    = hitCtrl | hitStatus | hitDrive;
  wire apbWrCtrl = apbAccess & apbReq.pwrite & hitCtrl;

  // Next driver state: force overrides bit 0 only
  wire [7:0] next_drive = {ctrlReg[7:1], ctrlReg[0] | forceLevel}; // [R7] [R8] [R9]

  // Control register: serial commit wins over a software write in same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlReg    <= slsoc_pkg::SLSOC_CTRL_RESET;               // [R10]
      frameCount <= 8'h00;
    end else if (commitPulse) begin
      ctrlReg    <= capturedWord;                               // [R2] [R5]
      frameCount <= frameCount + 8'h01;
    end else if (apbWrCtrl) begin
      ctrlReg    <= apbReq.pwdata[7:0];                         // [R2]
    end
  end

  // Driver outputs registered from control state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      driver_on_bits <= 8'h00;                                  // [R10]
    end else begin
      driver_on_bits <= next_drive;                             // [R7]
    end
  end

  assign low_side_driver_one = driver_on_bits[0];               // [R9]

  // Read data mux
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[slsoc_pkg::SLSOC_ST_FORCE_BIT] = forceLevel;
    statusWord[slsoc_pkg::SLSOC_ST_FRAME_BIT] = frameActive;
    statusWord[slsoc_pkg::SLSOC_ST_COUNT_MSB:slsoc_pkg::SLSOC_ST_COUNT_LSB] = frameCount;
  end

  wire [31:0] next_rdata = hitCtrl   ? {24'h000000, ctrlReg} :
                           hitStatus ? statusWord :
                           hitDrive  ? {24'h000000, driver_on_bits} : 32'h0000_0000;

  // Read data held in a flop, loaded in setup phase
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (apbReq.psel & ~apbReq.penable & ~apbReq.pwrite) begin
      prdata <= next_rdata;
    end
  end

  // Zero-wait slave; unmapped address answers with an error
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~hitAny;

endmodule
`default_nettype wire

// [testbench/slsoc_top_assertions.sv]
// Port checker for the serial low-side output controller
`timescale 1ns/1ps
`default_nettype none
module slsoc_checker (
  input wire logic                         mclk,
  input wire logic                         sys_rst,
  input wire logic                         select_n,
  input wire logic                         out_one_force_on,
  input wire slsoc_pkg::slsoc_apb_req_type apbReq,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic [31:0]                  prdata,
  input wire logic [7:0]                   driver_on_bits,
  input wire logic                         low_side_driver_one
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire acc = apbReq.psel & apbReq.penable;  // Access phase
  wire wr  = acc & apbReq.pwrite;           // Write lands here
  wire hole = !(apbReq.paddr inside {32'h0, 32'h4, 32'h8});  // Unmapped
  a_one_mirror: assert property (low_side_driver_one == driver_on_bits[0]) else $error("pin one off bit");
  a_force_on: assert property (out_one_force_on [*4] |-> low_side_driver_one) else $error("force lost");
  // Drivers 7 to 1 move only on commit or register write, and mid frame only after a register write
  a_frame_quiet: assert property ($changed(driver_on_bits[7:1]) |-> select_n || $past(wr) || $past(wr, 2))
    else $error("drivers moved in frame");
  a_reset_off: assert property (disable iff (1'b0) sys_rst |-> driver_on_bits == 8'h00) else $error("on in reset");
  a_err_decode: assert property (acc |-> pslverr == hole) else $error("bad error decode");
  a_hole_zero: assert property (acc && !apbReq.pwrite && hole |-> prdata == 32'h0) else $error("hole read data");
  a_ready_high: assert property (pready) else $error("not ready");
  a_read_hold: assert property ($changed(prdata) |-> $past(apbReq.psel & !apbReq.penable & !apbReq.pwrite))
    else $error("read data moved");
endmodule
bind slsoc_top slsoc_checker i_chk (.*);
`default_nettype wire

// [testbench/slsoc_serial_master.sv]
// Serial master model: frames MSB first on a 125 ns link clock
`timescale 1ns/1ps
`default_nettype none
module slsoc_serial_master (
  output var logic serialClock,
  output var logic select_n,
  output var logic serialData
);
  // Idle: clock low, deselected
  initial begin
    serialClock = 1'b0;
    select_n = 1'b1;
    serialData = 1'b0;
  end
  // One frame; x adds prefix byte p ahead of v
  task automatic send(input logic [7:0] v, input bit x = 0, input logic [7:0] p = 8'h00);
    logic [15:0] w;
    w = {p, v};
    select_n = 1'b0;
    #40;  // Select settles before clocking
    for (int i = x ? 15 : 7; i >= 0; i--) begin
      serialData = w[i];
      #62.5 serialClock = 1'b1;
      #62.5 serialClock = 1'b0;
    end
    #80 select_n = 1'b1;
    serialData = ~serialData;  // Released line shows no stale bit
    #300;  // Commit and word spacing
  endtask
endmodule
`default_nettype wire

// [testbench/serial_low_side_output_control_test.sv]
// Self-checking bench for the serial low-side output controller
`timescale 1ns/1ps
`default_nettype none
module serial_low_side_output_control_test;
  logic                         mclk, sys_rst = 1'b1, out_one_force_on = 1'b0;
  logic                         serialClock, select_n, serialData, pready, pslverr, low_side_driver_one, err;
  slsoc_pkg::slsoc_apb_req_type apbReq = '0;  // APB request
  logic [31:0]                  prdata, rd;   // Read data, sampled copy
  logic [7:0]                   driver_on_bits;
  logic [7:0]                   vals[4] = '{8'hA5, 8'h5A, 8'h80, 8'h01};
  int                           mismatches = 0, nTests = 0;
  slsoc_top i_dut (.*);
  slsoc_serial_master i_spi (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // One APB transfer, waits for ready
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge mclk) apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk) apbReq.penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
  endtask
  task automatic chk(input logic [31:0] g, e);
    nTests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Frames, force pin, register map, second reset
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    foreach (vals[i]) begin
      i_spi.send(vals[i]);
      chk(32'(driver_on_bits), 32'(vals[i]));
      apb(1'b0, 32'h0, 32'h0);
      chk(rd, 32'(vals[i]));
    end
    i_spi.send(8'h3C, 1'b1, 8'hFF);
    chk(32'(driver_on_bits), 32'h3C);
    @(posedge mclk) out_one_force_on <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(32'(driver_on_bits), 32'h3D);
    @(posedge mclk) out_one_force_on <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(32'(low_side_driver_one), 32'h0);
    apb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h0000_0500);
    apb(1'b1, 32'h0, 32'h81);
    apb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h81);
    apb(1'b0, 32'hC, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    sys_rst <= 1'b1;
    @(posedge mclk) sys_rst <= 1'b0;
    chk(32'(driver_on_bits), 32'h0);
    apb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
  // Hang guard
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
